// ===== design/pmm_mapper.sv
// Paged management memory: host byte access, page and bank mapping
`timescale 1ns/1ns
//
// Behaviour
// - Host addresses eight-bit bytes, 256 locations
// - Lower 00h-7Fh, upper 80h-FFh
// - Paged: one 128-byte page in upper
// - Bank selects among instances of a page
// - Lower always reachable; selects live there
// - Lower plus page 00h always implemented
// - Flat: page 00h fixed, no switching
// - Flat content is read-only static image
// - Paged adds 01h, 02h, bank0 10h/11h
// - Only advertised pages and banks exist
// - Bank n of 10h-2Fh covers lanes 8n+1..8n+8
// - Broadcast write reaches page in every bank
module pmm_mapper #(
    parameter bit PAGED = 1'b1,
    parameter int NUM_BANKS = 2,
    parameter bit BCAST_SUPPORTED = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire pmm_pkg::pmm_byte_t i_acc_addr,
    input wire pmm_pkg::pmm_byte_t i_acc_wdata,
    input wire logic i_ld_valid,
    input wire logic [$clog2(pmm_pkg::PMM_REG_BANKED
        + pmm_pkg::PMM_REG_PER_BANK * NUM_BANKS) + 6:0] i_ld_addr,
    input wire pmm_pkg::pmm_byte_t i_ld_data,
    output logic o_rd_valid,
    output pmm_pkg::pmm_byte_t o_rd_data,
    output pmm_pkg::pmm_byte_t o_sel_page,
    output pmm_pkg::pmm_byte_t o_sel_bank,
    output logic o_sel_valid,
    output logic o_bcast_en
);
    import pmm_pkg::*;

    localparam int NREG = PMM_REG_BANKED + PMM_REG_PER_BANK * NUM_BANKS;
    localparam int RW = $clog2(NREG);
    localparam int MW = RW + PMM_OFS_W;

    logic [7:0] mem [NREG * PMM_PAGE_BYTES];

    pmm_state_t st;
    pmm_state_t next_st;
    logic mem_we;
    logic bcast_all;
    logic [MW-1:0] acc_idx;
    logic acc_ok;
    logic [RW:0] sel_map;
    logic [RW:0] next_map;
    logic is_upper;
    logic [6:0] ofs;
    logic rd_req;
    logic wr_req;
    logic p11_sel;

    // Region of the selected page and bank, with a valid bit on top
    function automatic logic [RW:0] map_sel(input logic [7:0] pg,
                                            input logic [7:0] bk);
        logic v;
        int r;
        v = 1'b0;
        r = 0;
        if (pg == PMM_PAGE_00) begin
            v = 1'b1;
            r = PMM_REG_P00;
        end else if (PAGED) begin
            if (pg == PMM_PAGE_01) begin
                v = 1'b1;
                r = PMM_REG_P01;
            end else if (pg == PMM_PAGE_02) begin
                v = 1'b1;
                r = PMM_REG_P02;
            end else if ((pg == PMM_PAGE_10 || pg == PMM_PAGE_11)
                         && int'(bk) < NUM_BANKS) begin
                v = 1'b1;
                r = PMM_REG_BANKED + PMM_REG_PER_BANK * int'(bk)
                    + int'(pg == PMM_PAGE_11);
            end
        end
        // Anything else is not advertised and stays unmapped
        return {v, RW'(r)};
    endfunction

    assign is_upper = i_acc_addr[PMM_UPPER_BIT];
    assign ofs = i_acc_addr[PMM_OFS_W-1:0];
    assign rd_req = i_acc_valid && !i_acc_write;
    assign wr_req = i_acc_valid && i_acc_write;
    assign sel_map = map_sel(st.page, st.bank);
    assign p11_sel = (st.page == PMM_PAGE_11);

    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        mem_we = 1'b0;
        bcast_all = 1'b0;
        // Upper shows the one selected region, lower is always region 0
        if (is_upper) begin
            acc_idx = {sel_map[RW-1:0], ofs};
            acc_ok = sel_map[RW];
        end else begin
            acc_idx = {RW'(PMM_REG_LOWER), ofs};
            acc_ok = 1'b1;
        end
        if (rd_req) begin
            next_st.rd_valid = 1'b1;
            if (!is_upper && ofs == PMM_OFS_PAGE_SEL) begin
                next_st.rd_data = st.page;
            end else if (!is_upper && ofs == PMM_OFS_BANK_SEL) begin
                next_st.rd_data = st.bank;
            end else if (!is_upper && ofs == PMM_OFS_CTRL) begin
                next_st.rd_data = {7'h00, st.bcast};
            end else if (acc_ok) begin
                next_st.rd_data = mem[acc_idx];
            end else begin
                next_st.rd_data = PMM_UNMAPPED_DATA;
            end
        end
        // A flat image never takes host writes
        if (wr_req && PAGED) begin
            if (!is_upper && ofs == PMM_OFS_PAGE_SEL) begin
                next_st.page = i_acc_wdata;
            end else if (!is_upper && ofs == PMM_OFS_BANK_SEL) begin
                next_st.bank = i_acc_wdata;
            end else if (!is_upper && ofs == PMM_OFS_CTRL) begin
                next_st.bcast = i_acc_wdata[PMM_CTRL_BCAST_BIT]
                    & BCAST_SUPPORTED;
            end else if (acc_ok) begin
                mem_we = 1'b1;
                // Only the lane banked pages fan out to every bank
                bcast_all = is_upper && st.bcast
                    && (st.page == PMM_PAGE_10 || p11_sel);
            end
        end
        next_map = map_sel(next_st.page, next_st.bank);
        next_st.sel_valid = next_map[RW];
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st.page <= PMM_PAGE_RST;
            st.bank <= PMM_BANK_RST;
            st.bcast <= 1'b0;
            st.sel_valid <= 1'b1;
            st.rd_valid <= 1'b0;
            st.rd_data <= PMM_DATA_RST;
        end else begin
            st <= next_st;
        end
    end

    // Storage has no reset; the loader port fills the static image.
    // A host write wins the cycle, the loader entry is then dropped.
    always_ff @(posedge i_sys_clk) begin
        if (mem_we) begin
            if (bcast_all) begin
                for (int b = 0; b < NUM_BANKS; b++) begin
                    mem[MW'((PMM_REG_BANKED + PMM_REG_PER_BANK * b
                             + int'(p11_sel)) * PMM_PAGE_BYTES
                            + int'(ofs))] <= i_acc_wdata;
                end
            end else begin
                mem[acc_idx] <= i_acc_wdata;
            end
        end else if (i_ld_valid) begin
            mem[i_ld_addr] <= i_ld_data;
        end
    end

    assign o_rd_valid = st.rd_valid;
    assign o_rd_data = st.rd_data;
    assign o_sel_page = st.page;
    assign o_sel_bank = st.bank;
    assign o_sel_valid = st.sel_valid;
    assign o_bcast_en = st.bcast;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_read_answer;
        rd_req |=> o_rd_valid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered in one cycle");

    property p_no_spurious;
        !rd_req |=> !o_rd_valid;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("answer without read");

    property p_segment;
        rd_req && !is_upper |-> acc_ok && acc_idx[MW-1:PMM_OFS_W] == '0;
    endproperty
    a_segment: assert property (p_segment)
        else $error("lower address left region zero");

    property p_page_sel;
        wr_req && !is_upper && ofs == PMM_OFS_PAGE_SEL && PAGED
            |=> o_sel_page == $past(i_acc_wdata);
    endproperty
    a_page_sel: assert property (p_page_sel)
        else $error("page select not taken");

    property p_bank_sel;
        wr_req && !is_upper && ofs == PMM_OFS_BANK_SEL && PAGED
            |=> o_sel_bank == $past(i_acc_wdata);
    endproperty
    a_bank_sel: assert property (p_bank_sel)
        else $error("bank select not taken");

    property p_sel_readback;
        rd_req && !is_upper && ofs == PMM_OFS_PAGE_SEL
            |=> o_rd_data == $past(o_sel_page);
    endproperty
    a_sel_readback: assert property (p_sel_readback)
        else $error("page select readback wrong");

    property p_page0;
        o_sel_page == PMM_PAGE_00 |-> o_sel_valid;
    endproperty
    a_page0: assert property (p_page0)
        else $error("page 00h not mapped");

    property p_flat;
        !PAGED |-> o_sel_page == PMM_PAGE_00 && !mem_we;
    endproperty
    a_flat: assert property (p_flat)
        else $error("flat device switched or written");

    property p_mandatory;
        PAGED && o_sel_bank == 8'h00 && (o_sel_page == PMM_PAGE_01
            || o_sel_page == PMM_PAGE_02 || o_sel_page == PMM_PAGE_10
            || o_sel_page == PMM_PAGE_11) |-> o_sel_valid;
    endproperty
    a_mandatory: assert property (p_mandatory)
        else $error("mandatory page not mapped");

    property p_unadvertised;
        o_sel_page == 8'h03 || (o_sel_page == PMM_PAGE_10
            && int'(o_sel_bank) >= NUM_BANKS) |-> !o_sel_valid;
    endproperty
    a_unadvertised: assert property (p_unadvertised)
        else $error("unsupported page or bank mapped");

    property p_unmapped_read;
        rd_req && is_upper && !o_sel_valid
            |=> o_rd_data == PMM_UNMAPPED_DATA;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped upper read not zero");

    property p_bcast;
        wr_req && is_upper && o_bcast_en && o_sel_valid && PAGED
            && (o_sel_page == PMM_PAGE_10 || o_sel_page == PMM_PAGE_11)
            |-> bcast_all && mem_we;
    endproperty
    a_bcast: assert property (p_bcast)
        else $error("broadcast write not fanned out");

    property p_upper_region;
        rd_req && is_upper && o_sel_valid
            |-> acc_idx[MW-1:PMM_OFS_W] != RW'(PMM_REG_LOWER);
    endproperty
    a_upper_region: assert property (p_upper_region)
        else $error("upper read landed in lower region");

    // Bank n of a lane banked page sits PER_BANK regions above bank n-1
    property p_lane_bank;
        rd_req && is_upper && o_sel_valid && o_sel_page == PMM_PAGE_10
            |-> int'(acc_idx[MW-1:PMM_OFS_W]) == PMM_REG_BANKED
                + PMM_REG_PER_BANK * int'(o_sel_bank);
    endproperty
    a_lane_bank: assert property (p_lane_bank)
        else $error("lane bank mapped to wrong region");

    property p_offset;
        rd_req && acc_ok
            |-> acc_idx[PMM_OFS_W-1:0] == i_acc_addr[PMM_OFS_W-1:0];
    endproperty
    a_offset: assert property (p_offset)
        else $error("byte offset not carried through");

    property p_bcast_enable;
        wr_req && !is_upper && ofs == PMM_OFS_CTRL && PAGED
            && BCAST_SUPPORTED && i_acc_wdata[PMM_CTRL_BCAST_BIT]
            |=> o_bcast_en;
    endproperty
    a_bcast_enable: assert property (p_bcast_enable)
        else $error("broadcast enable not taken");

    property p_no_bcast;
        !o_bcast_en |-> !bcast_all;
    endproperty
    a_no_bcast: assert property (p_no_bcast)
        else $error("fan out without broadcast enable");

    c_page_switch: cover property (wr_req && !is_upper
        && ofs == PMM_OFS_PAGE_SEL ##1 rd_req && is_upper);
    c_bank1_read: cover property (rd_req && is_upper && o_sel_valid
        && o_sel_bank == 8'h01);
    c_bcast_write: cover property (mem_we && bcast_all);
    c_unmapped: cover property (rd_req && is_upper && !o_sel_valid);
endmodule

// ===== design/pmm_pkg.sv
// Shared constants and state type of the paged management memory mapper
package pmm_pkg;
    typedef logic [7:0] pmm_byte_t;

    // Host byte address space and its two segments
    localparam int PMM_ADDR_W = 8;
    localparam int PMM_SPACE_BYTES = 256;
    localparam int PMM_PAGE_BYTES = 128;
    localparam int PMM_OFS_W = 7;
    localparam logic [7:0] PMM_LOWER_FIRST = 8'h00;
    localparam logic [7:0] PMM_LOWER_LAST = 8'h7f;
    localparam logic [7:0] PMM_UPPER_FIRST = 8'h80;
    localparam logic [7:0] PMM_UPPER_LAST = 8'hff;
    localparam int PMM_UPPER_BIT = 7;

    // Select bytes held in the lower segment
    localparam logic [6:0] PMM_OFS_PAGE_SEL = 7'h7f;
    localparam logic [6:0] PMM_OFS_BANK_SEL = 7'h7e;
    localparam logic [6:0] PMM_OFS_CTRL = 7'h7d;
    localparam int PMM_CTRL_BCAST_BIT = 0;

    // Page numbers
    localparam logic [7:0] PMM_PAGE_00 = 8'h00;
    localparam logic [7:0] PMM_PAGE_01 = 8'h01;
    localparam logic [7:0] PMM_PAGE_02 = 8'h02;
    localparam logic [7:0] PMM_PAGE_10 = 8'h10;
    localparam logic [7:0] PMM_PAGE_11 = 8'h11;
    localparam logic [7:0] PMM_LANE_GRP1_FIRST = 8'h10;
    localparam logic [7:0] PMM_LANE_GRP1_LAST = 8'h1f;
    localparam logic [7:0] PMM_LANE_GRP2_FIRST = 8'h20;
    localparam logic [7:0] PMM_LANE_GRP2_LAST = 8'h2f;
    localparam int PMM_LANES_PER_BANK = 8;

    // Internal regions: lower, page 00h, 01h, 02h, then 10h/11h per bank
    localparam int PMM_REG_LOWER = 0;
    localparam int PMM_REG_P00 = 1;
    localparam int PMM_REG_P01 = 2;
    localparam int PMM_REG_P02 = 3;
    localparam int PMM_REG_BANKED = 4;
    localparam int PMM_REG_PER_BANK = 2;

    // Reset values and unmapped read data
    localparam logic [7:0] PMM_PAGE_RST = 8'h00;
    localparam logic [7:0] PMM_BANK_RST = 8'h00;
    localparam logic [7:0] PMM_DATA_RST = 8'h00;
    localparam logic [7:0] PMM_UNMAPPED_DATA = 8'h00;

    typedef struct packed {
        logic [7:0] page;
        logic [7:0] bank;
        logic bcast;
        logic sel_valid;
        logic rd_valid;
        logic [7:0] rd_data;
    } pmm_state_t;
endpackage

// ===== sim/pmm_host.sv
// Host controller model issuing byte accesses on the management port
`timescale 1ns/1ns
module pmm_host (
    input wire logic i_sys_clk,
    input wire logic i_rd_valid,
    input wire pmm_pkg::pmm_byte_t i_rd_data,
    output logic o_acc_valid,
    output logic o_acc_write,
    output pmm_pkg::pmm_byte_t o_acc_addr,
    output pmm_pkg::pmm_byte_t o_acc_wdata
);
    import pmm_pkg::*;
    initial begin
        o_acc_valid = 1'b0;
        o_acc_write = 1'b0;
        o_acc_addr = 8'h00;
        o_acc_wdata = 8'h00;
    end
    // Stays valid so the next call can follow at the very next edge
    task automatic put(input logic w, input pmm_byte_t a, input pmm_byte_t d);
        @(posedge i_sys_clk);
        o_acc_valid <= 1'b1;
        o_acc_write <= w;
        o_acc_addr <= a;
        o_acc_wdata <= d;
    endtask
    task automatic idle();
        @(posedge i_sys_clk);
        o_acc_valid <= 1'b0;
    endtask
    // Selection is written before any upper access that relies on it
    task automatic sel(input pmm_byte_t pg, input pmm_byte_t bk);
        put(1'b1, 8'h7e, bk);
        put(1'b1, 8'h7f, pg);
    endtask
    task automatic rd(input pmm_byte_t a, output logic v, output pmm_byte_t d);
        put(1'b0, a, 8'h00);
        // The answer stands only in the cycle after the taking edge
        idle();
        #1;
        v = i_rd_valid;
        d = i_rd_data;
    endtask
endmodule

// ===== sim/pmm_mapper_test.sv
// Self-checking bench of the paged management memory mapper
`timescale 1ns/1ns
module pmm_mapper_test;
    import pmm_pkg::*;
    localparam int LDW = $clog2(PMM_REG_BANKED + PMM_REG_PER_BANK * 2) + 7;
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] bank;
        logic w;
        logic [7:0] addr;
        logic [7:0] data;
    } pmm_row_t;
    logic clk = 1'b0;
    logic rst_n;
    logic ld_valid;
    logic [LDW-1:0] ld_addr;
    logic [7:0] ld_data;
    logic acc_valid, acc_write, rd_valid, sel_valid, bcast_en;
    logic f_rd_valid, f_sel_valid, f_bcast_en, v;
    logic [7:0] acc_addr, acc_wdata, rd_data, sel_page, sel_bank, d;
    logic [7:0] f_rd_data, f_sel_page, f_sel_bank;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    // Write rows carry data, read rows the expected byte
    pmm_row_t rows [19] = '{
        '{8'h00, 8'h00, 1'b1, 8'h10, 8'ha5}, '{8'h01, 8'h00, 1'b0, 8'h10, 8'ha5},
        '{8'h01, 8'h00, 1'b1, 8'h80, 8'h11}, '{8'h02, 8'h00, 1'b1, 8'h80, 8'h22},
        '{8'h01, 8'h00, 1'b0, 8'h80, 8'h11}, '{8'h02, 8'h00, 1'b0, 8'h80, 8'h22},
        '{8'h01, 8'h00, 1'b0, 8'h7f, 8'h01}, '{8'h10, 8'h00, 1'b1, 8'h85, 8'h33},
        '{8'h10, 8'h01, 1'b1, 8'h85, 8'h44}, '{8'h10, 8'h00, 1'b0, 8'h85, 8'h33},
        '{8'h10, 8'h01, 1'b0, 8'h85, 8'h44}, '{8'h03, 8'h00, 1'b1, 8'h80, 8'h99},
        '{8'h03, 8'h00, 1'b0, 8'h80, 8'h00}, '{8'h10, 8'h02, 1'b0, 8'h85, 8'h00},
        '{8'h00, 8'h00, 1'b1, 8'h85, 8'h66}, '{8'h00, 8'h05, 1'b0, 8'h85, 8'h66},
        '{8'h11, 8'h00, 1'b1, 8'h7d, 8'h01}, '{8'h11, 8'h01, 1'b1, 8'h90, 8'h5a},
        '{8'h11, 8'h00, 1'b0, 8'h90, 8'h5a}};

    always #5 clk = ~clk;

    pmm_host host (.i_sys_clk(clk), .i_rd_valid(rd_valid),
        .i_rd_data(rd_data), .o_acc_valid(acc_valid),
        .o_acc_write(acc_write), .o_acc_addr(acc_addr),
        .o_acc_wdata(acc_wdata));
    // Paged instance runs on the default parameters
    pmm_mapper dut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_acc_valid(acc_valid),
        .i_acc_write(acc_write), .i_acc_addr(acc_addr),
        .i_acc_wdata(acc_wdata), .i_ld_valid(ld_valid), .i_ld_addr(ld_addr),
        .i_ld_data(ld_data), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .o_sel_page(sel_page), .o_sel_bank(sel_bank),
        .o_sel_valid(sel_valid), .o_bcast_en(bcast_en));
    // Flat twin sees the same host and loader traffic
    pmm_mapper #(.PAGED(1'b0), .NUM_BANKS(2), .BCAST_SUPPORTED(1'b1)) dut_flat (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_acc_valid(acc_valid),
        .i_acc_write(acc_write), .i_acc_addr(acc_addr),
        .i_acc_wdata(acc_wdata), .i_ld_valid(ld_valid), .i_ld_addr(ld_addr),
        .i_ld_data(ld_data), .o_rd_valid(f_rd_valid), .o_rd_data(f_rd_data),
        .o_sel_page(f_sel_page), .o_sel_bank(f_sel_bank),
        .o_sel_valid(f_sel_valid), .o_bcast_en(f_bcast_en));

    task automatic chk(input string n, input logic [15:0] e, logic [15:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic ld(input logic [LDW-8:0] r, input logic [6:0] o,
        input logic [7:0] dt);
        @(posedge clk);
        ld_valid <= 1'b1;
        ld_addr <= {r, o};
        ld_data <= dt;
        @(posedge clk);
        ld_valid <= 1'b0;
    endtask
    task automatic selchk(input logic [7:0] pg, bk, input logic ok);
        host.sel(pg, bk);
        host.idle();
        #1;
        chk("select", {pg, bk}, {sel_page, sel_bank});
        chk("sel valid", {15'h0, ok}, {15'h0, sel_valid});
    endtask
    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        ld_valid = 1'b0;
        ld_addr = '0;
        ld_data = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset sel", 16'h0000, {sel_page, sel_bank});
        chk("reset flags", 16'h0004,
            {13'h0, sel_valid, bcast_en, rd_valid});
        ld(3'h0, 7'h10, 8'he1);
        ld(3'h1, 7'h05, 8'hc3);
        foreach (rows[i]) begin
            host.sel(rows[i].page, rows[i].bank);
            if (rows[i].w) begin
                host.put(1'b1, rows[i].addr, rows[i].data);
            end else begin
                host.rd(rows[i].addr, v, d);
                chk("rd valid", 16'h0001, {15'h0, v});
                chk("rd data", {8'h00, rows[i].data}, {8'h00, d});
            end
        end
        chk("bcast en", 16'h0001, {15'h0, bcast_en});
        selchk(8'h03, 8'h00, 1'b0);
        selchk(8'h10, 8'h02, 1'b0);
        selchk(8'h11, 8'h01, 1'b1);
        chk("flat sel", 16'h0000, {f_sel_page, 7'h0, f_bcast_en});
        host.rd(8'h10, v, d);
        chk("flat lower", 16'h01e1, {7'h0, f_rd_valid, f_rd_data});
        host.rd(8'h85, v, d);
        chk("flat page0", 16'h00c3, {8'h00, f_rd_data});
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk("mid reset", 16'h0000, {sel_page, sel_bank});
        chk("mid bcast", 16'h0000, {15'h0, bcast_en});
        @(posedge clk);
        rst_n <= 1'b1;
        finish_test();
    end
endmodule
